// File: design/sbrg_pkg.sv
// Purpose: Shared constants and types for the serial baud rate generator
// Assumes: AHB-Lite register access, 32-bit data, one word per register
// Notes: Register offsets are byte addresses
package sbrg_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DIV_LOW = 8'h04;
    localparam logic [7:0] OFS_DIV_HIGH = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned CTRL_SYNC_BIT = 1;
    localparam int unsigned CTRL_WIDE_BIT = 2;
    localparam int unsigned CTRL_HS_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic [5:0] PRE_ASYNC_SLOW = 6'h3F;
    localparam logic [5:0] PRE_ASYNC_FAST = 6'h0F;
    localparam logic [5:0] PRE_SYNC = 6'h03;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic enable;
        logic sync_mode;
        logic wide_divider_select;
        logic high_speed_select;
    } sbrg_cfg_s;

    typedef enum logic [1:0] {
        SBRG_IDLE = 2'b00,
        SBRG_RUN = 2'b01
    } sbrg_state_e;
endpackage

// File: design/sbrg_prescale.sv
// Purpose: Fixed prescaler before the divisor counter
// Assumes: Single clock, synchronous reset
// Notes: Emits one pulse every limit+1 clocks
`timescale 1ns/1ns
`default_nettype none
module sbrg_prescale (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic [5:0] limit,
    // Tick out
    output logic tick
);
    logic [5:0] cnt_q, cnt_d;
    logic tick_d;

    always_comb begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (!run) begin
            cnt_d = 6'h00;
        end else if (cnt_q >= limit) begin
            cnt_d = 6'h00;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 6'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_q <= 6'h00;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end
endmodule // sbrg_prescale
`default_nettype wire

// File: design/sbrg_divcount.sv
// Purpose: Down counter dividing the prescaled tick by n+1
// Assumes: Ticks are one-cycle pulses
// Notes: Reload on terminal count keeps period exactly n+1 ticks
`timescale 1ns/1ns
`default_nettype none
module sbrg_divcount #(
    parameter int unsigned W = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic tick,
    input wire logic [W-1:0] divisor,
    // Rate out
    output logic rate_pulse
);
    logic [W-1:0] cnt_q, cnt_d;
    logic pulse_d;

    always_comb begin
        cnt_d = cnt_q;
        pulse_d = 1'b0;
        if (!run) begin
            cnt_d = divisor;
        end else if (tick) begin
            if (cnt_q == '0) begin
                cnt_d = divisor;
                pulse_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_q <= '0;
            rate_pulse <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            rate_pulse <= pulse_d;
        end
    end
endmodule // sbrg_divcount
`default_nettype wire

// File: design/sbrg_top.sv
// Purpose: Baud rate generator with programmable divisor over AHB-Lite
// Assumes: clk_sys is the oscillator; single word transfers; rst synchronous
// Notes: Output pulse rate is clk_sys / (prescale * (n+1))
// Notes on behaviour
// - Async, 8-bit, high-speed clear: rate is oscillator over 64 times (n+1).
// - Async, 8-bit, high-speed set: rate is oscillator over 16 times (n+1).
// - Sync: rate is oscillator over 4 times (n+1); high-speed ignored.
// - Wide select picks 16-bit counting, else 8-bit, in both modes.
// - n is the divisor low register, with the high register above it in wide mode.
`timescale 1ns/1ns
`default_nettype none
module sbrg_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Rate output
    output logic rate_tick
);
    sbrg_pkg::sbrg_cfg_s cfg_q, cfg_d;
    logic [7:0] div_low_q, div_low_d;
    logic [7:0] div_high_q, div_high_d;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_addr_q, wr_addr_d;
    logic [31:0] rdata_d;
    logic [15:0] divisor;
    logic [5:0] pre_limit;
    logic pre_tick;
    logic div_pulse;
    logic run;
    logic phase_q;
    sbrg_pkg::sbrg_state_e state_q, state_d;
    logic [15:0] div_seen_q;

    function automatic logic [5:0] prescale_sel(input sbrg_pkg::sbrg_cfg_s c);
        if (c.sync_mode) begin
            prescale_sel = sbrg_pkg::PRE_SYNC;
        end else if (c.wide_divider_select) begin
            prescale_sel = c.high_speed_select ? sbrg_pkg::PRE_SYNC : sbrg_pkg::PRE_ASYNC_FAST;
        end else begin
            prescale_sel = c.high_speed_select ? sbrg_pkg::PRE_ASYNC_FAST : sbrg_pkg::PRE_ASYNC_SLOW;
        end
    endfunction

    // Narrow counting drops the high byte so stale high values do no harm
    assign divisor = cfg_q.wide_divider_select ? {div_high_q, div_low_q} : {8'h00, div_low_q};
    assign pre_limit = prescale_sel(cfg_q);
    assign run = (state_q == sbrg_pkg::SBRG_RUN);

    // Any config write restarts the chain so the new period starts clean
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            sbrg_pkg::SBRG_IDLE: begin
                if (cfg_q.enable && !wr_pend_q) begin
                    state_d = sbrg_pkg::SBRG_RUN;
                end
            end
            sbrg_pkg::SBRG_RUN: begin
                if (!cfg_q.enable || wr_pend_q) begin
                    state_d = sbrg_pkg::SBRG_IDLE;
                end
            end
            default: state_d = sbrg_pkg::SBRG_IDLE;
        endcase
    end

    sbrg_prescale u_pre (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(run),
        .limit(pre_limit),
        .tick(pre_tick)
    );

    sbrg_divcount #(.W(16)) u_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(run),
        .tick(pre_tick),
        .divisor(divisor),
        .rate_pulse(div_pulse)
    );

    // Bus: zero wait states, writes land in the data phase
    always_comb begin
        cfg_d = cfg_q;
        div_low_d = div_low_q;
        div_high_d = div_high_q;
        wr_pend_d = 1'b0;
        wr_addr_d = wr_addr_q;
        rdata_d = 32'h00000000;
        if (wr_pend_q) begin
            unique case (wr_addr_q)
                sbrg_pkg::OFS_CTRL: begin
                    cfg_d.enable = hwdata[sbrg_pkg::CTRL_ENABLE_BIT];
                    cfg_d.sync_mode = hwdata[sbrg_pkg::CTRL_SYNC_BIT];
                    cfg_d.wide_divider_select = hwdata[sbrg_pkg::CTRL_WIDE_BIT];
                    cfg_d.high_speed_select = hwdata[sbrg_pkg::CTRL_HS_BIT];
                end
                sbrg_pkg::OFS_DIV_LOW: div_low_d = hwdata[7:0];
                sbrg_pkg::OFS_DIV_HIGH: div_high_d = hwdata[7:0];
                default: begin
                end
            endcase
        end
        if (hsel && hready && htrans[1]) begin
            if (hwrite) begin
                wr_pend_d = 1'b1;
                wr_addr_d = haddr[7:0];
            end else begin
                unique case (haddr[7:0])
                    sbrg_pkg::OFS_CTRL: rdata_d = {28'h0000000, cfg_q.high_speed_select,
                        cfg_q.wide_divider_select, cfg_q.sync_mode, cfg_q.enable};
                    sbrg_pkg::OFS_DIV_LOW: rdata_d = {24'h000000, div_low_q};
                    sbrg_pkg::OFS_DIV_HIGH: rdata_d = {24'h000000, div_high_q};
                    sbrg_pkg::OFS_STATUS: rdata_d = {30'h00000000, phase_q, run};
                    default: rdata_d = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_q <= sbrg_pkg::CTRL_RESET;
            div_low_q <= sbrg_pkg::DIV_RESET;
            div_high_q <= sbrg_pkg::DIV_RESET;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            state_q <= sbrg_pkg::SBRG_IDLE;
            rate_tick <= 1'b0;
            phase_q <= 1'b0;
            div_seen_q <= 16'h0000;
        end else begin
            cfg_q <= cfg_d;
            div_low_q <= div_low_d;
            div_high_q <= div_high_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            hrdata <= rdata_d;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            state_q <= state_d;
            rate_tick <= div_pulse;
            phase_q <= div_pulse ? ~phase_q : phase_q;
            div_seen_q <= divisor;
        end
    end

    // Helper: cycles since last rate tick while configuration is stable
    logic [23:0] gap_q;
    logic gap_valid_q;
    logic [23:0] expect_gap;
    // Widen before adding so the slow prescale of 64 cannot wrap in six bits
    assign expect_gap = (24'(pre_limit) + 24'h000001) * (24'(divisor) + 24'h000001);
    always_ff @(posedge clk_sys) begin
        if (rst || !run || wr_pend_q || divisor != div_seen_q) begin
            gap_q <= 24'h000000;
            gap_valid_q <= 1'b0;
        end else if (rate_tick) begin
            gap_q <= 24'h000001;
            gap_valid_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 24'h000001;
        end
    end

    property p_period;
        @(posedge clk_sys) disable iff (rst)
        (rate_tick && gap_valid_q && run && !wr_pend_q) |-> (gap_q == expect_gap);
    endproperty
    a_period: assert property (p_period) else $error("rate period mismatch");

    property p_slow_async;
        @(posedge clk_sys) disable iff (rst)
        (!cfg_q.sync_mode && !cfg_q.wide_divider_select && !cfg_q.high_speed_select) |-> (pre_limit == 6'h3F);
    endproperty
    a_slow_async: assert property (p_slow_async) else $error("async slow prescale wrong");

    property p_fast_async;
        @(posedge clk_sys) disable iff (rst)
        (!cfg_q.sync_mode && !cfg_q.wide_divider_select && cfg_q.high_speed_select) |-> (pre_limit == 6'h0F);
    endproperty
    a_fast_async: assert property (p_fast_async) else $error("async fast prescale wrong");

    property p_sync;
        @(posedge clk_sys) disable iff (rst)
        cfg_q.sync_mode |-> (pre_limit == 6'h03);
    endproperty
    a_sync: assert property (p_sync) else $error("sync prescale wrong");

    property p_narrow;
        @(posedge clk_sys) disable iff (rst)
        !cfg_q.wide_divider_select |-> (divisor[15:8] == 8'h00);
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow divider uses high byte");

    property p_pair;
        @(posedge clk_sys) disable iff (rst)
        cfg_q.wide_divider_select |-> (divisor == {div_high_q, div_low_q});
    endproperty
    a_pair: assert property (p_pair) else $error("divisor not the register pair");

    property p_wide_async;
        @(posedge clk_sys) disable iff (rst)
        (!cfg_q.sync_mode && cfg_q.wide_divider_select) |->
            (pre_limit == (cfg_q.high_speed_select ? 6'h03 : 6'h0F));
    endproperty
    a_wide_async: assert property (p_wide_async) else $error("async wide prescale wrong");

    property p_tick_one;
        @(posedge clk_sys) disable iff (rst)
        (rate_tick && pre_limit != 6'h00) |=> !rate_tick;
    endproperty
    a_tick_one: assert property (p_tick_one) else $error("rate tick longer than a cycle");

    property p_write_lands;
        @(posedge clk_sys) disable iff (rst)
        (hsel && hready && htrans[1] && hwrite && haddr[7:0] == sbrg_pkg::OFS_DIV_LOW) ##1 1'b1 |=>
            (div_low_q == $past(hwdata[7:0]));
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("divisor low write lost");

    // Bus answer and restart path
    property p_bus_okay;
        @(posedge clk_sys) disable iff (rst)
        hreadyout && !hresp;
    endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready and okay");

    property p_write_high;
        @(posedge clk_sys) disable iff (rst)
        (hsel && hready && htrans[1] && hwrite && haddr[7:0] == sbrg_pkg::OFS_DIV_HIGH) ##1 1'b1 |=>
            (div_high_q == $past(hwdata[7:0]));
    endproperty
    a_write_high: assert property (p_write_high) else $error("divisor high write lost");

    property p_status_zero;
        @(posedge clk_sys) disable iff (rst)
        (hsel && hready && htrans[1] && !hwrite && haddr[7:0] == sbrg_pkg::OFS_STATUS) |=>
            (hrdata[31:2] == 30'h00000000);
    endproperty
    a_status_zero: assert property (p_status_zero) else $error("status upper bits not zero");

    property p_restart;
        @(posedge clk_sys) disable iff (rst)
        wr_pend_q |=> !run;
    endproperty
    a_restart: assert property (p_restart) else $error("write did not restart the chain");

    // Two register stages sit between the divider and the pin
    property p_tick_run;
        @(posedge clk_sys) disable iff (rst)
        rate_tick |-> $past(run, 2);
    endproperty
    a_tick_run: assert property (p_tick_run) else $error("rate tick while stopped");

    property p_idle_quiet;
        @(posedge clk_sys) disable iff (rst)
        (!run ##1 !run ##1 !run) |-> !rate_tick;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("rate tick after stop");

    property p_low_byte;
        @(posedge clk_sys) disable iff (rst)
        divisor[7:0] == div_low_q;
    endproperty
    a_low_byte: assert property (p_low_byte) else $error("divisor low byte not the register");

    property p_phase;
        @(posedge clk_sys) disable iff (rst)
        rate_tick == (phase_q != $past(phase_q));
    endproperty
    a_phase: assert property (p_phase) else $error("status phase out of step");

    property p_hold;
        @(posedge clk_sys) disable iff (rst)
        !wr_pend_q |=> ($stable(cfg_q) && $stable(div_low_q) && $stable(div_high_q));
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without a write");

    c_slow: cover property (@(posedge clk_sys) disable iff (rst)
        rate_tick && !cfg_q.sync_mode && !cfg_q.high_speed_select);
    c_sync: cover property (@(posedge clk_sys) disable iff (rst) rate_tick && cfg_q.sync_mode);
    c_wide: cover property (@(posedge clk_sys) disable iff (rst) rate_tick && cfg_q.wide_divider_select);
    c_fast: cover property (@(posedge clk_sys) disable iff (rst)
        rate_tick && !cfg_q.sync_mode && cfg_q.high_speed_select);
    c_restart: cover property (@(posedge clk_sys) disable iff (rst) wr_pend_q && run);
endmodule // sbrg_top
`default_nettype wire

// File: sim/tb_serial_baud_rate_generator.sv
// Purpose: Self-checking bench for the serial baud rate generator
// Assumes: Zero-wait AHB-Lite slave, hready fed back from hreadyout
// Notes: Small divisors keep the run short; wide mode uses n=258
`timescale 1ns/1ns
`default_nettype none
module tb_serial_baud_rate_generator;
    logic clk_sys;
    logic rst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    wire logic hresp;
    wire logic rate_tick;
    int bad_count;
    int checked;

    sbrg_top dut (
        .clk_sys(clk_sys),
        .rst(rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .rate_tick(rate_tick)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        if (bad_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One single transfer; the slave decides when each phase ends
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= sbrg_pkg::HTRANS_NONSEQ;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h00000000;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
        check({31'h00000000, hresp}, 32'h00000000);
    endtask

    function automatic logic [31:0] cfg(input logic s, input logic w, input logic h);
        cfg = 32'h00000000;
        cfg[sbrg_pkg::CTRL_ENABLE_BIT] = 1'b1;
        cfg[sbrg_pkg::CTRL_SYNC_BIT] = s;
        cfg[sbrg_pkg::CTRL_WIDE_BIT] = w;
        cfg[sbrg_pkg::CTRL_HS_BIT] = h;
    endfunction

    // Counts ticks over a fixed span; used where the output must stay quiet
    task automatic quiet(input int span);
        int ticks;
        ticks = 0;
        repeat (span) begin
            @(posedge clk_sys);
            if (rate_tick !== 1'b0) ticks++;
        end
        check(ticks, 0);
    endtask

    task automatic reset_values;
        logic [31:0] rd;
        bus(1'b0, sbrg_pkg::OFS_CTRL, 32'h0, rd);
        check(rd, 32'h00000000);
        bus(1'b0, sbrg_pkg::OFS_DIV_LOW, 32'h0, rd);
        check(rd, 32'h00000000);
        bus(1'b0, sbrg_pkg::OFS_DIV_HIGH, 32'h0, rd);
        check(rd, 32'h00000000);
        bus(1'b0, sbrg_pkg::OFS_STATUS, 32'h0, rd);
        check(rd, 32'h00000000);
        quiet(100);
    endtask

    // Unused upper bits must read back as zero; unmapped space is inert
    task automatic reg_access;
        logic [31:0] rd;
        bus(1'b1, sbrg_pkg::OFS_CTRL, 32'hFFFFFFF0, rd);
        bus(1'b0, sbrg_pkg::OFS_CTRL, 32'h0, rd);
        check(rd, 32'h00000000);
        bus(1'b1, sbrg_pkg::OFS_DIV_LOW, 32'hFFFFFFFF, rd);
        bus(1'b0, sbrg_pkg::OFS_DIV_LOW, 32'h0, rd);
        check(rd, 32'h000000FF);
        bus(1'b1, sbrg_pkg::OFS_DIV_HIGH, 32'hFFFFFF5A, rd);
        bus(1'b0, sbrg_pkg::OFS_DIV_HIGH, 32'h0, rd);
        check(rd, 32'h0000005A);
        bus(1'b1, 8'h10, 32'hFFFFFFFF, rd);
        bus(1'b0, 8'h10, 32'h0, rd);
        check(rd, 32'h00000000);
        quiet(50);
    endtask

    // Programs a mode, then times two whole periods between ticks
    task automatic run_mode(input logic [31:0] ctrl, input logic [7:0] hi, input logic [7:0] lo, input int pre);
        logic [31:0] rd;
        int n;
        int cnt;
        n = ctrl[sbrg_pkg::CTRL_WIDE_BIT] ? int'({hi, lo}) : int'(lo);
        bus(1'b1, sbrg_pkg::OFS_DIV_HIGH, {24'h000000, hi}, rd);
        bus(1'b1, sbrg_pkg::OFS_DIV_LOW, {24'h000000, lo}, rd);
        bus(1'b1, sbrg_pkg::OFS_CTRL, ctrl, rd);
        do @(posedge clk_sys); while (rate_tick !== 1'b1);
        repeat (2) begin
            cnt = 0;
            do begin
                @(posedge clk_sys);
                cnt++;
            end while (rate_tick !== 1'b1);
            check(cnt, pre * (n + 1));
        end
    endtask

    // High byte is nonzero in 8-bit cases except the n=0 sync run, so a wrong width shows up
    task automatic all_modes;
        run_mode(cfg(1'b0, 1'b0, 1'b0), 8'h05, 8'h02, 64);
        run_mode(cfg(1'b0, 1'b0, 1'b1), 8'h05, 8'h02, 16);
        run_mode(cfg(1'b1, 1'b0, 1'b0), 8'h05, 8'h02, 4);
        run_mode(cfg(1'b1, 1'b0, 1'b1), 8'h05, 8'h02, 4);
        run_mode(cfg(1'b1, 1'b0, 1'b0), 8'h00, 8'h00, 4);
        run_mode(cfg(1'b0, 1'b1, 1'b0), 8'h01, 8'h02, 16);
        run_mode(cfg(1'b0, 1'b1, 1'b1), 8'h01, 8'h02, 4);
        run_mode(cfg(1'b1, 1'b1, 1'b0), 8'h01, 8'h02, 4);
        run_mode(cfg(1'b1, 1'b1, 1'b1), 8'h01, 8'h02, 4);
    endtask

    // Stop by clearing enable, then a reset in mid-run
    task automatic stop_and_reset;
        logic [31:0] rd;
        bus(1'b1, sbrg_pkg::OFS_CTRL, 32'h00000000, rd);
        quiet(100);
        run_mode(cfg(1'b1, 1'b0, 1'b0), 8'h00, 8'h01, 4);
        bus(1'b0, sbrg_pkg::OFS_STATUS, 32'h0, rd);
        check({31'h00000000, rd[0]}, 32'h00000001);
        @(posedge clk_sys);
        rst <= 1'b1;
        hsel <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        bus(1'b0, sbrg_pkg::OFS_CTRL, 32'h0, rd);
        check(rd, 32'h00000000);
        bus(1'b0, sbrg_pkg::OFS_STATUS, 32'h0, rd);
        check(rd, 32'h00000000);
        quiet(50);
    endtask

    initial begin
        bad_count = 0;
        checked = 0;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = sbrg_pkg::HSIZE_WORD;
        hwdata = 32'h00000000;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        reset_values();
        reg_access();
        all_modes();
        stop_and_reset();
        print_verdict();
    end

    // About four times the expected run length
    initial begin
        #900000;
        bad_count++;
        print_verdict();
    end
endmodule // tb_serial_baud_rate_generator
`default_nettype wire
